/* radio_frame_assembler.sv */
// Radio frame assembler: radiometry, time tags and I/Q pairs interleaved into
// 5082-byte frames, streamed one byte at a time.
// Assumes the second strobe is asynchronous and the sample stream and input
// selection come from logic on mclk.
`timescale 1ns/1ps
module radio_frame_assembler
  import frame_pkg::*;
#(
  parameter int PAIR_CYCLES = PAIR_CYC_DEF
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Timing strobe
  input  wire logic               second_strobe,
  // Sample stream
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample_data,
  input  wire logic [2:0]         input_select,
  // Frame byte stream
  output logic [7:0]              out_byte,
  output logic                    out_valid,
  output logic                    out_first
);

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } state_t;

  typedef struct packed {
    state_t          state;
    logic [2:0]      sync;
    logic            strobe_lvl;
    logic [PAIR_CNT_W-1:0] pair_cyc;
    logic [6:0]      pair_idx;
    logic [3:0]      tenth;
    logic [39:0]     rad_acc;
    logic [39:0]     rad_snap;
    logic [23:0]     tag_cnt;
    logic [23:0]     tag_snap;
    logic [7:0]      status;
    logic [12:0]     pos;
    logic [1:0]      sub;
    logic            pair_avail;
    logic [15:0]     hold_i;
    logic [15:0]     hold_q;
    logic [7:0]      obyte;
    logic            ovalid;
    logic            ofirst;
  } fa_state_t;

  fa_state_t s_q;
  fa_state_t s_d;

  logic               strobe_rise;
  logic               go;
  logic               pair_tick;
  logic               tenth_tick;
  logic               frame_tick;
  logic [31:0]        sq;
  slot_kind_t         kind;
  logic [2:0]         byte_idx;
  logic               stall;
  logic               pair_valid;
  logic signed [15:0] pair_i;
  logic signed [15:0] pair_q;

  // ==========================================================================
  // Submodules
  frame_slot_decoder u_slot (
    .pos      (s_q.pos),
    .kind     (kind),
    .byte_idx (byte_idx)
  );

  iq_downconverter u_dc (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_valid (sample_valid),
    .sample_data  (sample_data),
    .restart      (go),
    .dump         (pair_tick),
    .pair_valid   (pair_valid),
    .pair_i       (pair_i),
    .pair_q       (pair_q)
  );

  // ==========================================================================
  // Event decode
  // Only the second and third stages are compared, so a metastable first
  // stage can never produce a false start.
  assign strobe_rise = (s_q.sync[1] == s_q.sync[2]) && s_q.sync[2] && !s_q.strobe_lvl;
  // framing begins on the first strobe edge after reset
  assign go          = (s_q.state == ST_WAIT) && strobe_rise;
  assign pair_tick   = (s_q.state == ST_RUN) &&
                       (s_q.pair_cyc == PAIR_CNT_W'(PAIR_CYCLES - 1));
  assign tenth_tick  = pair_tick && (s_q.pair_idx == 7'(PAIRS_PER_TENTH - 1));
  assign frame_tick  = tenth_tick && (s_q.tenth == 4'(TENTHS - 1));
  assign sq          = 32'(sample_data) * 32'(sample_data);
  // an I/Q slot waits for the next pair to be ready
  assign stall       = (kind == SLOT_IQ) && (s_q.sub == 2'h0) && !s_q.pair_avail;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d        = s_q;
    s_d.sync   = {s_q.sync[1:0], second_strobe};
    s_d.ovalid = 1'b0;
    s_d.ofirst = 1'b0;
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.strobe_lvl = s_q.sync[2];
    end

    unique case (s_q.state)
      ST_WAIT: begin
        if (go) begin
          s_d.state    = ST_RUN;
          s_d.pair_cyc = '0;
          s_d.pair_idx = 7'h00;
          s_d.tenth    = 4'h0;
          s_d.pos      = ID_POS;
          s_d.sub      = 2'h0;
          // first value of a fresh start covers no time
          s_d.rad_snap = 40'h00_0000_0000;
          // integration starts with the first frame
          s_d.rad_acc  = sample_valid ? 40'(sq) : 40'h00_0000_0000;
          // the first tag after start is zero
          s_d.tag_snap = 24'h00_0000;
          s_d.tag_cnt  = 24'h00_0001;
          s_d.status   = 8'({input_select, 4'h0});
        end
      end
      ST_RUN: begin
        // the frame timer free-runs; framing never stops once begun
        s_d.pair_cyc = s_q.pair_cyc + PAIR_CNT_W'(1);
        if (pair_tick) begin
          s_d.pair_cyc = '0;
          s_d.pair_idx = s_q.pair_idx + 7'h01;
        end
        if (tenth_tick) begin
          s_d.pair_idx = 7'h00;
          s_d.tenth    = s_q.tenth + 4'h1;
        end

        // square and sum at the sample rate
        if (sample_valid) begin
          s_d.rad_acc = s_q.rad_acc + 40'(sq);
        end
        // snapshot every tenth of a frame
        if (tenth_tick) begin
          s_d.rad_snap = s_q.rad_acc;
          s_d.tag_snap = s_q.tag_cnt;
          // the tag keeps counting across frames
          s_d.tag_cnt  = s_q.tag_cnt + 24'h00_0001;
        end
        if (frame_tick) begin
          s_d.tenth   = 4'h0;
          s_d.rad_acc = sample_valid ? 40'(sq) : 40'h00_0000_0000;
          s_d.status  = 8'({input_select, 4'h0});
        end

        // Serializer walks positions independently of frame timing; it reaches
        // each I/Q slot tens of thousands of cycles early and stalls for the pair.
        if (!stall) begin
          // one byte per cycle in position order
          s_d.ovalid = 1'b1;
          s_d.ofirst = (s_q.pos == ID_POS);
          s_d.pos    = (s_q.pos == FRAME_LEN) ? ID_POS : s_q.pos + 13'h0001;
          unique case (kind)
            SLOT_ID:     s_d.obyte = FRAME_ID;
            SLOT_STATUS: s_d.obyte = s_q.status;
            SLOT_RAD:    s_d.obyte = pick_byte(s_q.rad_snap, byte_idx, 3'(RAD_BYTES));
            SLOT_TAG:    s_d.obyte = pick_byte(40'(s_q.tag_snap), byte_idx, 3'(TAG_BYTES));
            SLOT_IQ: begin
              // I high, I low, Q high, Q low
              unique case (s_q.sub)
                2'h0: s_d.obyte = s_q.hold_i[15:8];
                2'h1: s_d.obyte = s_q.hold_i[7:0];
                2'h2: s_d.obyte = s_q.hold_q[15:8];
                2'h3: s_d.obyte = s_q.hold_q[7:0];
              endcase
              s_d.sub = s_q.sub + 2'h1;
              if (s_q.sub == 2'h3) begin
                s_d.pair_avail = 1'b0;
              end
            end
            default: s_d.obyte = 8'h00;
          endcase
        end
      end
      default: s_d.state = ST_WAIT;
    endcase

    // a new pair is taken after any clear so it is never lost
    if (pair_valid) begin
      s_d.hold_i     = pair_i;
      s_d.hold_q     = pair_q;
      s_d.pair_avail = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.state <= ST_WAIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_byte  = s_q.obyte;
  assign out_valid = s_q.ovalid;
  assign out_first = s_q.ofirst;

  // ==========================================================================
  // Checks
  chk_acc_square: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && sample_valid && !frame_tick |=>
      s_q.rad_acc == $past(s_q.rad_acc) + 40'($past(sq)))
    else $error("power accumulator did not add the squared sample");

  chk_acc_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    frame_tick |=>
      s_q.rad_acc == ($past(sample_valid) ? 40'($past(sq)) : 40'h00_0000_0000))
    else $error("accumulator not cleared at frame start");

  chk_rad_snap: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tenth_tick |=> s_q.rad_snap == $past(s_q.rad_acc))
    else $error("radiometry snapshot wrong at tenth boundary");

  chk_tag_start: assert property (
    @(posedge mclk) disable iff (sys_rst)
    go |=> s_q.tag_snap == 24'h00_0000 ##0 s_q.tag_cnt == 24'h00_0001)
    else $error("time tag did not start at zero");

  chk_tag_step: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tenth_tick |=> s_q.tag_cnt == $past(s_q.tag_cnt) + 24'h00_0001)
    else $error("time tag did not step by one");

  chk_id_marker: assert property (
    @(posedge mclk) disable iff (sys_rst)
    out_first |-> out_valid && out_byte == FRAME_ID)
    else $error("first byte is not the frame marker");

  chk_first_pos: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && !stall && s_q.pos == ID_POS |=> out_first)
    else $error("first-byte marker missing");

  chk_status_bits: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && !stall && kind == SLOT_STATUS |=>
      out_valid && out_byte[7] == 1'b0 && out_byte[3:0] == 4'h0)
    else $error("status byte has stray bits");

  chk_pos_wrap: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && !stall && s_q.pos == FRAME_LEN |=> s_q.pos == ID_POS)
    else $error("frame length is wrong");

  chk_idle_quiet: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_WAIT) |=> !out_valid)
    else $error("bytes emitted before start strobe");

  chk_pair_order: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && kind == SLOT_IQ && !stall && s_q.sub == 2'h3 |=>
      s_q.sub == 2'h0 && (!s_q.pair_avail || $past(pair_valid)))
    else $error("I/Q pair not consumed as a unit");

  chk_run_holds: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) |=> (s_q.state == ST_RUN))
    else $error("framing stopped after start");

  // A pair may only land on a full holding register in the cycle that empties it.
  chk_pair_kept: assert property (
    @(posedge mclk) disable iff (sys_rst)
    pair_valid && s_q.pair_avail |->
      (kind == SLOT_IQ) && (s_q.sub == 2'h3) && !stall)
    else $error("I/Q pair overwritten before it was sent");

  chk_status_pos: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && s_q.pos == STATUS_POS |-> kind == SLOT_STATUS)
    else $error("status byte not at its position");

  chk_tag_slot: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.state == ST_RUN) && s_q.pos == TAG_POS |-> kind == SLOT_TAG && byte_idx == 3'h0)
    else $error("first time tag byte misplaced");

  cov_start: cover property (@(posedge mclk) disable iff (sys_rst) go);
  cov_frame: cover property (@(posedge mclk) disable iff (sys_rst) frame_tick);
  cov_rad:   cover property (@(posedge mclk) disable iff (sys_rst)
                             (s_q.state == ST_RUN) && !stall && kind == SLOT_RAD);
  cov_wrap:  cover property (@(posedge mclk) disable iff (sys_rst)
                             (s_q.state == ST_RUN) && !stall && s_q.pos == FRAME_LEN);

endmodule : radio_frame_assembler

/* frame_pkg.sv */
// Constants, types and helpers shared by the radio frame assembler and its submodules.
// Assumes a single 100 MHz clock and frame bytes numbered from one.
package frame_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TENTH_NS        = 102_400_000;
  localparam int PAIRS_PER_TENTH = 125;
  localparam int TENTHS          = 10;
  localparam int PAIRS_PER_FRAME = 1250;
  localparam int TENTH_CYC       = TENTH_NS / CLK_PERIOD_NS;
  localparam int PAIR_CYC_DEF    = TENTH_CYC / PAIRS_PER_TENTH;
  localparam int PAIR_CNT_W      = 17;
  // Boxcar length of 8192 samples per pair at 10 Msample/s.
  localparam int DEC_SHIFT       = 13;

  // ==========================================================================
  // Frame layout
  localparam logic [12:0] FRAME_LEN   = 13'h13DA;
  localparam logic [12:0] ID_POS      = 13'h0001;
  localparam logic [12:0] I1_POS      = 13'h0002;
  localparam logic [12:0] STATUS_POS  = 13'h0004;
  localparam logic [12:0] Q1_POS      = 13'h0005;
  localparam logic [12:0] HEAD_LEN    = 13'h0006;
  localparam logic [12:0] RAD_POS     = 13'h0007;
  localparam logic [12:0] TAG_POS     = 13'h0016;
  localparam logic [12:0] FIELD_STEP  = 13'h0003;
  localparam logic [12:0] CHUNK_LEN   = 13'h01FC;
  localparam int          RAD_BYTES   = 5;
  localparam int          TAG_BYTES   = 3;
  localparam logic [7:0]  FRAME_ID    = 8'hB7;
  localparam int          STATUS_LSB  = 4;

  typedef enum logic [2:0] {
    SLOT_ID,
    SLOT_STATUS,
    SLOT_RAD,
    SLOT_TAG,
    SLOT_IQ
  } slot_kind_t;

  // Picks byte idx of an nbytes-wide value, most significant byte as idx 0.
  function automatic logic [7:0] pick_byte(input logic [39:0] v,
                                           input logic [2:0]  idx,
                                           input logic [2:0]  nbytes);
    logic [5:0]  amt;
    logic [39:0] sh;
    amt = {3'(nbytes - idx - 3'h1), 3'h0};
    sh  = v >> amt;
    return sh[7:0];
  endfunction : pick_byte

endpackage : frame_pkg

/* frame_slot_decoder.sv */
// Maps a frame byte position to the field that owns it.
// Pure combinational; position is 1..5082 from the framer.
`timescale 1ns/1ps
module frame_slot_decoder
  import frame_pkg::*;
(
  // Position in
  input  wire logic [12:0] pos,
  // Slot out
  output slot_kind_t       kind,
  output logic [2:0]       byte_idx
);

  logic [12:0] off;
  logic [12:0] chunk;
  logic [12:0] rem;
  logic [12:0] row;
  logic [12:0] col;

  // ==========================================================================
  // Decode
  always_comb begin
    off      = pos - RAD_POS;
    chunk    = off / CHUNK_LEN;
    rem      = off - 13'(chunk * CHUNK_LEN);
    row      = rem / FIELD_STEP;
    col      = rem - 13'(row * FIELD_STEP);
    kind     = SLOT_IQ;
    byte_idx = 3'h0;
    if (pos == ID_POS) begin
      kind = SLOT_ID;
    end else if (pos == STATUS_POS) begin
      kind = SLOT_STATUS;
    end else if (pos <= HEAD_LEN) begin
      kind = SLOT_IQ;
    end else if (row < 13'(RAD_BYTES) && col == 13'h0000) begin
      kind     = SLOT_RAD;
      byte_idx = row[2:0];
    // tag bytes follow in same column
    end else if (row < 13'(RAD_BYTES + TAG_BYTES) && col == 13'h0000) begin
      kind     = SLOT_TAG;
      byte_idx = 3'(row - 13'(RAD_BYTES));
    end else begin
      kind = SLOT_IQ;
    end
  end

endmodule : frame_slot_decoder

/* iq_downconverter.sv */
// Mixes the sample stream from a quarter-rate IF to zero and integrates
// each pair interval into one I/Q pair. Samples arrive from same-clock logic.
`timescale 1ns/1ps
module iq_downconverter
  import frame_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Samples
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample_data,
  // Control from framer
  input  wire logic               restart,
  input  wire logic               dump,
  // Pair out
  output logic                    pair_valid,
  output logic signed [15:0]      pair_i,
  output logic signed [15:0]      pair_q
);

  typedef struct packed {
    logic [1:0]         phase;
    logic signed [31:0] acc_i;
    logic signed [31:0] acc_q;
    logic               valid;
    logic signed [15:0] out_i;
    logic signed [15:0] out_q;
  } dc_state_t;

  dc_state_t s_q;
  dc_state_t s_d;

  logic signed [31:0] x;
  logic signed [31:0] add_i;
  logic signed [31:0] add_q;

  // ==========================================================================
  // Mixer and integrate-and-dump
  always_comb begin
    s_d   = s_q;
    x     = 32'(sample_data);
    add_i = 32'sh0000_0000;
    add_q = 32'sh0000_0000;
    // the IF sits at a quarter of the sample rate, so the
    // oscillator reduces to 1, -j, -1, +j and needs no multiplier.
    if (sample_valid) begin
      unique case (s_q.phase)
        2'h0: add_i = x;
        2'h1: add_q = -x;
        2'h2: add_i = -x;
        2'h3: add_q = x;
      endcase
      s_d.phase = s_q.phase + 2'h1;
    end
    s_d.valid = 1'b0;
    if (restart) begin
      s_d.phase = 2'h0;
      s_d.acc_i = 32'sh0000_0000;
      s_d.acc_q = 32'sh0000_0000;
    end else if (dump) begin
      // boxcar output scaled back to 16-bit signed
      s_d.out_i = s_q.acc_i[DEC_SHIFT+15:DEC_SHIFT];
      s_d.out_q = s_q.acc_q[DEC_SHIFT+15:DEC_SHIFT];
      s_d.valid = 1'b1;
      s_d.acc_i = add_i;
      s_d.acc_q = add_q;
    end else begin
      s_d.acc_i = s_q.acc_i + add_i;
      s_d.acc_q = s_q.acc_q + add_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pair_valid = s_q.valid;
  assign pair_i     = s_q.out_i;
  assign pair_q     = s_q.out_q;

endmodule : iq_downconverter

/* recorder_sink.sv */
// Far-side model: the data handling unit that records frames byte by byte.
// Assumes bytes arrive on mclk with a one-cycle valid; it never stalls the source.
`timescale 1ns/1ps
module recorder_sink (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Frame byte stream
  input  wire logic [7:0] out_byte,
  input  wire logic       out_valid,
  input  wire logic       out_first,
  // Capture state
  output logic [1:0]      frames_seen,
  output logic [12:0]     fill_pos,
  output logic [12:0]     first_len
);
  // Only the first two frames are kept, enough to see the frame wrap.
  logic [7:0]  mem [0:1][1:5082];
  logic [12:0] pos_w;
  logic [1:0]  idx_w;

  assign pos_w = out_first ? 13'h0001 : fill_pos + 13'h0001;
  assign idx_w = out_first ? frames_seen : frames_seen - 2'h1;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frames_seen <= 2'h0;
      fill_pos    <= 13'h0000;
      first_len   <= 13'h0000;
    end else if (out_valid) begin
      fill_pos <= pos_w;
      if (out_first && frames_seen == 2'h1) begin
        first_len <= fill_pos;
      end
      if (out_first && frames_seen != 2'h3) begin
        frames_seen <= frames_seen + 2'h1;
      end
      if (idx_w < 2'h2 && pos_w <= 13'h13DA && frames_seen != 2'h0 | out_first) begin
        mem[idx_w[0]][pos_w] <= out_byte;
      end
    end
  end
endmodule : recorder_sink

/* radio_frame_assembler_tb_top.sv */
// Testbench: starts framing on a strobe, records two frames and checks the layout.
// Assumes PAIR_CYCLES can be shortened; samples arrive every tenth clock.
`timescale 1ns/1ps
module radio_frame_assembler_tb_top;
  import frame_pkg::*;
  localparam int          PAIR_CYC = 48;
  localparam int          PER_TENTH = PAIRS_PER_TENTH * PAIR_CYC / 10;
  localparam logic [39:0] SQ = 40'h00_0000_0009;

  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              second_strobe = 1'b0;
  logic              sample_valid = 1'b0;
  logic signed [15:0] sample_data = 16'h0003;
  logic [2:0]        input_select = 3'h5;
  logic [7:0]        out_byte;
  logic              out_valid;
  logic              out_first;
  logic [1:0]        frames_seen;
  logic [12:0]       fill_pos;
  logic [12:0]       first_len;
  logic [3:0]        gap = 4'h0;
  int                bad_count = 0;
  int                checked = 0;

  always #5 mclk = ~mclk;

  // Constant sample every ten clocks, so each tenth holds a fixed count.
  always @(posedge mclk) begin
    gap          <= (gap == 4'h9) ? 4'h0 : gap + 4'h1;
    sample_valid <= (gap == 4'h9);
  end

  radio_frame_assembler #(.PAIR_CYCLES(PAIR_CYC)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .second_strobe(second_strobe),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .input_select(input_select), .out_byte(out_byte), .out_valid(out_valid),
    .out_first(out_first));

  recorder_sink u_rec (
    .mclk(mclk), .sys_rst(sys_rst), .out_byte(out_byte), .out_valid(out_valid),
    .out_first(out_first), .frames_seen(frames_seen), .fill_pos(fill_pos),
    .first_len(first_len));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Slot kind of a position: 0 id, 1 status, 2 radiometry, 3 tag, 4 I/Q.
  function automatic int slot_of(input int p);
    int r;
    if (p == 1) return 0;
    if (p == 4) return 1;
    if (p < 7) return 4;
    r = (p - 7) % 508;
    if (r <= 12 && r % 3 == 0) return 2;
    if (r >= 15 && r <= 21 && r % 3 == 0) return 3;
    return 4;
  endfunction : slot_of

  task automatic check_chunk(input int f, input int c, input logic [39:0] rad,
                             input logic [23:0] tag);
    logic [39:0] rv;
    logic [23:0] tv;
    rv = 40'h0;
    tv = 24'h0;
    for (int b = 0; b < 5; b++) rv = {rv[31:0], u_rec.mem[f][7 + 3 * b + 508 * c]};
    for (int b = 0; b < 3; b++) tv = {tv[15:0], u_rec.mem[f][22 + 3 * b + 508 * c]};
    check(rv, rad);
    check({16'h0, tv}, {16'h0, tag});
  endtask : check_chunk

  task automatic test_start_on_strobe();
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      #1;
      check({39'h0, out_valid}, 40'h0);
    end
    @(posedge mclk);
    second_strobe <= 1'b1;
    for (int i = 0; i < 20 && out_first !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check({39'h0, out_first}, 40'h1);
    check({32'h0, out_byte}, {32'h0, FRAME_ID});
    @(posedge mclk);
    second_strobe <= 1'b0;
  endtask : test_start_on_strobe

  task automatic test_run_two_frames();
    repeat (500) @(posedge mclk);
    // A later strobe must not restart framing.
    second_strobe <= 1'b1;
    input_select  <= 3'h2;
    repeat (10) @(posedge mclk);
    second_strobe <= 1'b0;
    for (int i = 0; i < 70000 && !(frames_seen == 2'h2 && fill_pos > 13'h001E); i++) begin
      @(posedge mclk);
    end
    check({38'h0, frames_seen}, 40'h2);
    check({27'h0, first_len}, {27'h0, FRAME_LEN});
  endtask : test_run_two_frames

  task automatic test_frame_layout();
    int n_iq;
    logic [7:0] b;
    n_iq = 0;
    check({32'h0, u_rec.mem[0][4]}, 40'h50);
    check({32'h0, u_rec.mem[1][4]}, 40'h20);
    check({32'h0, u_rec.mem[1][1]}, {32'h0, FRAME_ID});
    // tag and radiometry step per tenth
    for (int c = 0; c < 10; c++) begin
      check_chunk(0, c, SQ * PER_TENTH * c, 24'(c));
    end
    check_chunk(1, 0, SQ * PER_TENTH * 10, 24'h00_000A);
    // Small sums make every I/Q value 0 or -1, so its bytes are 00 or FF.
    for (int p = 1; p <= 5082; p++) begin
      if (slot_of(p) == 4) begin
        b = u_rec.mem[0][p];
        if (b == 8'h00 || b == 8'hFF) n_iq++;
        check({32'h0, b}, b[7] ? 40'hFF : 40'h0);
      end
    end
    check(40'(n_iq), 40'(4 * PAIRS_PER_FRAME));
  endtask : test_frame_layout

  initial begin
    #800us;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    test_start_on_strobe();
    test_run_two_frames();
    test_frame_layout();
    report_and_stop();
  end
endmodule : radio_frame_assembler_tb_top
